//--- logic/gcsu_defines.vh
// constants and rule summary for the gauge control subcommand unit
// Behaviour
// [R1] control command followed by two-byte subcommand
// [R2] sealed refuses 0x15, 0x20, 0x21, 0x41
// [R3] 0x0000 returns status word
// [R4] status high byte bit layout
// [R5] status low byte bit layout
// [R6] counter calibration about one minute after init
// [R7] init, done, failed need battery present
// [R8] hibernate and constant-power reset to zero
// [R9] 0x0001 returns device type code
// [R10] 0x0002 returns firmware version code
// [R11] 0x0007 returns previous code, above 9 gives 7; codes above 0x0014 are not recorded as previous code
// [R12] 0x0008 returns chemistry identifier
// [R13] measure subcommand only after init done
// [R14] measure at next tick, pulse 165 ms
// [R15] host cuts load within 8 ms
// [R16] measure while charge blocked sets failed
// [R17] 0x000D sets battery present when auto off
// [R18] 0x000E clears battery present when auto off
// [R19] auto detect uses thermistor when enabled
// [R20] 0x0011 sets hibernate, 0x0012 clears
// [R21] 0x0013 sets sleep-plus, 0x0014 clears
// [R22] 0x001F returns flash config version
// [R23] two transactions: command then data bytes
// [R24] hibernate bit clears on hibernate exit
// [R25] seal subcommand enters sealed state
// [R26] unknown or refused codes change nothing; unknown codes up to 0x0014 still become the previous code
`ifndef GCSU_DEFINES_VH
`define GCSU_DEFINES_VH
`define GCSU_I2C_ADDR        7'h55
`define GCSU_CMD_CTL_LO      8'h00
`define GCSU_CMD_CTL_HI      8'h01
`define GCSU_SC_STATUS       16'h0000
`define GCSU_SC_DEVTYPE      16'h0001
`define GCSU_SC_FWREV        16'h0002
`define GCSU_SC_LAST         16'h0007
`define GCSU_SC_CHEM         16'h0008
`define GCSU_SC_LAST_MAX     16'h0009
`define GCSU_SC_MEASURE      16'h000C
`define GCSU_SC_BAT_IN       16'h000D
`define GCSU_SC_BAT_OUT      16'h000E
`define GCSU_SC_HIB_SET      16'h0011
`define GCSU_SC_HIB_CLR      16'h0012
`define GCSU_SC_SLP_SET      16'h0013
`define GCSU_SC_SLP_CLR      16'h0014
`define GCSU_SC_FACTORY      16'h0015
`define GCSU_SC_FLASHREV     16'h001F
`define GCSU_SC_SEAL         16'h0020
`define GCSU_SC_ALGO_EN      16'h0021
`define GCSU_SC_FULL_RESET   16'h0041
`define GCSU_ST_FULL_LOCK    14
`define GCSU_ST_SS           13
`define GCSU_ST_CAL          11
`define GCSU_ST_BOARD_CAL    10
`define GCSU_ST_MDONE        9
`define GCSU_ST_MFAIL        8
`define GCSU_ST_INIT         7
`define GCSU_ST_HIB          6
`define GCSU_ST_SLP_PLUS     5
`define GCSU_ST_SLEEP        4
`define GCSU_ST_CPWR         3
`define GCSU_ST_RUPDIS       2
`define GCSU_ST_VVALID       1
`define GCSU_ST_QUPD         0
`define GCSU_CLK_HZ          100000000
`define GCSU_TICK_MS         1000
`define GCSU_PULSE_MS        165
`define GCSU_CAL_DELAY_S     60
`define GCSU_CAL_LEN_S       1
`define GCSU_TICK_CYC        ((`GCSU_CLK_HZ / 1000) * `GCSU_TICK_MS)
`define GCSU_PULSE_CYC       ((`GCSU_CLK_HZ / 1000) * `GCSU_PULSE_MS)
`endif

//--- logic/gcsu_sync.v
// two-flop synchroniser with edge detection after the second flop
`timescale 1ns/1ps
module gcsu_sync (
    // clock and reset
    input  wire clk,
    input  wire reset,
    // async input
    input  wire din,
    // synchronised outputs
    output reg  dout,
    output wire rise,
    output wire fall
);
    reg meta_r;
    reg last_r;
    always @(posedge clk) begin
        if (reset) begin
            meta_r <= 1'b1;
            dout   <= 1'b1;
            last_r <= 1'b1;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
            last_r <= dout;
        end
    end
    assign rise = dout & ~last_r;
    assign fall = ~dout & last_r;
endmodule

//--- logic/gcsu_tick.v
// free-running divider producing a one-cycle tick
`timescale 1ns/1ps
module gcsu_tick #(
    parameter PERIOD = 100000000
) (
    // clock and reset
    input  wire clk,
    input  wire reset,
    // tick pulse
    output reg  tick
);
    reg [31:0] cnt_r;
    always @(posedge clk) begin
        if (reset) begin
            cnt_r <= 32'h0;
            tick  <= 1'b0;
        end else if (cnt_r == PERIOD - 1) begin
            cnt_r <= 32'h0;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            tick  <= 1'b0;
        end
    end
endmodule

//--- logic/gcsu_top.v
// control subcommand unit with i2c slave front end
`timescale 1ns/1ps
`include "gcsu_defines.vh"
module gcsu_top #(
    parameter TICK_CYC   = `GCSU_TICK_CYC,
    parameter PULSE_CYC  = `GCSU_PULSE_CYC,
    parameter CAL_DELAY  = `GCSU_CAL_DELAY_S,
    parameter [15:0] DEV_TYPE  = 16'h1234,
    parameter [15:0] FW_REV    = 16'h0100,
    parameter [15:0] CHEM_CODE = 16'h0000,
    parameter [15:0] FLASH_REV = 16'h0000
) (
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // serial link pins
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_oe_n,
    // gauge side inputs
    input  wire        auto_insert_detect_en,
    input  wire        thermistor_present,
    input  wire        charge_blocked_flag,
    input  wire        hibernate_exit,
    input  wire        sleep_mode_in,
    input  wire        board_cal_in,
    input  wire        constant_power_in,
    input  wire        resistance_update_off_in,
    // outputs
    output reg         soc_int,
    output reg         battery_present_flag,
    output reg  [15:0] gauge_status_word,
    output reg         factory_restore_pulse,
    output reg         full_reset_pulse
);
    // arbitrary identity values above
    localparam S_IDLE = 3'h0;
    localparam S_ADDR = 3'h1;
    localparam S_ACK  = 3'h2;
    localparam S_RX   = 3'h3;
    localparam S_TX   = 3'h4;
    localparam S_TACK = 3'h5;
    localparam S_SKIP = 3'h6;

    wire scl_s, scl_rise, scl_fall;
    wire sda_s, sda_rise, sda_fall;
    wire tick;

    gcsu_sync u_scl (.clk(clk), .reset(reset), .din(scl_in), .dout(scl_s), .rise(scl_rise), .fall(scl_fall));
    gcsu_sync u_sda (.clk(clk), .reset(reset), .din(sda_in), .dout(sda_s), .rise(sda_rise), .fall(sda_fall));
    gcsu_tick #(.PERIOD(TICK_CYC)) u_tick (.clk(clk), .reset(reset), .tick(tick));

    wire start_c = scl_s & sda_fall;
    wire stop_c  = scl_s & sda_rise;

    reg  [2:0]  st_r;
    reg  [3:0]  bit_r;
    reg  [7:0]  sh_r;
    reg         rw_r;
    reg         first_r;
    reg  [7:0]  ptr_r;
    reg  [15:0] wdata_r;
    reg         lo_got_r;
    reg         sc_go_r;
    reg  [15:0] sc_r;
    reg  [15:0] resp_r;
    reg  [15:0] last_sc_r;
    reg         sealed_r;
    reg         full_lock_r;
    reg         hib_r;
    reg         slp_plus_r;
    reg         init_r;
    reg         mdone_r;
    reg         mfail_r;
    reg         vvalid_r;
    reg         qupd_r;
    reg         cal_r;
    reg  [6:0]  sec_r;
    reg         meas_pend_r;
    reg  [31:0] pulse_r;

    function restricted;
        input [15:0] c;
        begin
            restricted = (c == `GCSU_SC_FACTORY) || (c == `GCSU_SC_SEAL) ||
                         (c == `GCSU_SC_ALGO_EN) || (c == `GCSU_SC_FULL_RESET);
        end
    endfunction

    function [7:0] tx_byte;
        input [7:0]  p;
        input [15:0] w;
        begin
            if (p == `GCSU_CMD_CTL_LO)
                tx_byte = w[7:0];
            else if (p == `GCSU_CMD_CTL_HI)
                tx_byte = w[15:8];
            else
                tx_byte = 8'h00;
        end
    endfunction

    wire [7:0]  tx_w = tx_byte(ptr_r, resp_r);

    // i2c slave: command byte then data bytes, two transactions
    always @(posedge clk) begin
        if (reset) begin
            st_r     <= S_IDLE;
            bit_r    <= 4'h0;
            sh_r     <= 8'h00;
            rw_r     <= 1'b0;
            first_r  <= 1'b0;
            ptr_r    <= 8'h00;
            wdata_r  <= 16'h0000;
            lo_got_r <= 1'b0;
            sc_go_r  <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            sc_go_r <= 1'b0;
            if (start_c) begin
                st_r     <= S_ADDR;
                bit_r    <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (stop_c) begin
                st_r     <= S_IDLE;
                sda_oe_n <= 1'b1;
            end else begin
                case (st_r)
                    S_ADDR, S_RX: begin
                        if (scl_rise) begin
                            sh_r  <= {sh_r[6:0], sda_s};
                            bit_r <= bit_r + 4'h1;
                        end
                        if (scl_fall && bit_r == 4'h8) begin
                            bit_r <= 4'h0;
                            if (st_r == S_ADDR) begin
                                if (sh_r[7:1] == `GCSU_I2C_ADDR) begin
                                    rw_r     <= sh_r[0];
                                    first_r  <= 1'b1;
                                    sda_oe_n <= 1'b0;
                                    st_r     <= S_ACK;
                                end else begin
                                    st_r <= S_SKIP;
                                end
                            end else begin
                                sda_oe_n <= 1'b0;
                                st_r     <= S_ACK;
                                if (first_r) begin
                                    ptr_r   <= sh_r; // [R23]
                                    first_r <= 1'b0;
                                end else begin
                                    ptr_r <= ptr_r + 8'h01;
                                    if (ptr_r == `GCSU_CMD_CTL_LO) begin
                                        wdata_r[7:0] <= sh_r; // [R1]
                                        lo_got_r     <= 1'b1;
                                    end else if (ptr_r == `GCSU_CMD_CTL_HI && lo_got_r) begin
                                        wdata_r[15:8] <= sh_r;
                                        lo_got_r      <= 1'b0;
                                        sc_go_r       <= 1'b1; // [R1]
                                    end
                                end
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            if (rw_r) begin
                                sh_r     <= tx_w;
                                sda_oe_n <= tx_w[7];
                                st_r     <= S_TX;
                            end else begin
                                sda_oe_n <= 1'b1;
                                st_r     <= S_RX;
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == 4'h7) begin
                                sda_oe_n <= 1'b1;
                                bit_r    <= 4'h0;
                                ptr_r    <= ptr_r + 8'h01;
                                st_r     <= S_TACK;
                            end else begin
                                sh_r     <= {sh_r[6:0], 1'b0};
                                sda_oe_n <= sh_r[6];
                            end
                        end
                    end
                    S_TACK: begin
                        if (scl_rise) begin
                            st_r <= sda_s ? S_SKIP : S_ACK;
                            first_r <= 1'b0;
                        end
                    end
                    default: begin
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    // subcommand decode and status keeping
    always @(posedge clk) begin
        if (reset) begin
            resp_r       <= 16'h0000;
            last_sc_r    <= 16'h0000;
            sealed_r     <= 1'b0;
            full_lock_r  <= 1'b0;
            hib_r        <= 1'b0; // [R8]
            slp_plus_r   <= 1'b0;
            init_r       <= 1'b0;
            mdone_r      <= 1'b0;
            mfail_r      <= 1'b0;
            vvalid_r     <= 1'b0;
            qupd_r       <= 1'b0;
            cal_r        <= 1'b0;
            sec_r        <= 7'h00;
            meas_pend_r  <= 1'b0;
            pulse_r      <= 32'h0;
            soc_int      <= 1'b0;
            battery_present_flag  <= 1'b0;
            factory_restore_pulse <= 1'b0;
            full_reset_pulse      <= 1'b0;
            gauge_status_word     <= 16'h0000;
        end else begin
            factory_restore_pulse <= 1'b0;
            full_reset_pulse      <= 1'b0;
            if (auto_insert_detect_en)
                battery_present_flag <= thermistor_present; // [R19]
            if (!battery_present_flag) begin
                init_r  <= 1'b0; // [R7]
                mdone_r <= 1'b0;
                mfail_r <= 1'b0;
            end else if (tick) begin
                init_r <= 1'b1; // [R7]
            end
            if (hibernate_exit)
                hib_r <= 1'b0; // [R24]
            // calibration about one minute after init
            if (!init_r) begin
                sec_r <= 7'h00;
                cal_r <= 1'b0;
            end else if (tick) begin
                if (sec_r == CAL_DELAY) begin
                    cal_r <= 1'b1; // [R6]
                    sec_r <= 7'h00;
                end else begin
                    cal_r <= 1'b0;
                    sec_r <= sec_r + 7'h01;
                end
            end
            // measurement window
            if (meas_pend_r && tick) begin
                meas_pend_r <= 1'b0;
                soc_int     <= 1'b1; // [R14]
                pulse_r     <= PULSE_CYC - 1;
            end else if (soc_int) begin
                if (pulse_r == 32'h0) begin
                    soc_int <= 1'b0;
                    if (battery_present_flag)
                        mdone_r <= 1'b1; // [R7]
                end else begin
                    pulse_r <= pulse_r - 32'h1; // [R14]
                end
            end
            if (sc_go_r && !(sealed_r && restricted(wdata_r))) begin // [R2] [R26]
                if (wdata_r <= `GCSU_SC_SLP_CLR)
                    last_sc_r <= wdata_r;
                if (wdata_r == `GCSU_SC_STATUS)
                    resp_r <= gauge_status_word; // [R3]
                else if (wdata_r == `GCSU_SC_DEVTYPE)
                    resp_r <= DEV_TYPE; // [R9]
                else if (wdata_r == `GCSU_SC_FWREV)
                    resp_r <= FW_REV; // [R10]
                else if (wdata_r == `GCSU_SC_LAST)
                    resp_r <= (last_sc_r > `GCSU_SC_LAST_MAX) ? `GCSU_SC_LAST : last_sc_r; // [R11]
                else if (wdata_r == `GCSU_SC_CHEM)
                    resp_r <= CHEM_CODE; // [R12]
                else if (wdata_r == `GCSU_SC_FLASHREV)
                    resp_r <= FLASH_REV; // [R22]
                else if (wdata_r == `GCSU_SC_MEASURE) begin
                    if (charge_blocked_flag && battery_present_flag)
                        mfail_r <= 1'b1; // [R16]
                    else if (init_r && !soc_int) begin
                        meas_pend_r <= 1'b1; // [R13]
                        mdone_r     <= 1'b0;
                        mfail_r     <= 1'b0;
                    end
                end else if (wdata_r == `GCSU_SC_BAT_IN) begin
                    if (!auto_insert_detect_en)
                        battery_present_flag <= 1'b1; // [R17]
                end else if (wdata_r == `GCSU_SC_BAT_OUT) begin
                    if (!auto_insert_detect_en)
                        battery_present_flag <= 1'b0; // [R18]
                end else if (wdata_r == `GCSU_SC_HIB_SET)
                    hib_r <= 1'b1; // [R20]
                else if (wdata_r == `GCSU_SC_HIB_CLR)
                    hib_r <= 1'b0; // [R20]
                else if (wdata_r == `GCSU_SC_SLP_SET)
                    slp_plus_r <= 1'b1; // [R21]
                else if (wdata_r == `GCSU_SC_SLP_CLR)
                    slp_plus_r <= 1'b0; // [R21]
                else if (wdata_r == `GCSU_SC_FACTORY)
                    factory_restore_pulse <= 1'b1;
                else if (wdata_r == `GCSU_SC_SEAL) begin
                    sealed_r <= 1'b1; // [R25]
                    full_lock_r <= 1'b1;
                end else if (wdata_r == `GCSU_SC_ALGO_EN) begin
                    vvalid_r <= 1'b1;
                    qupd_r   <= 1'b1;
                end else if (wdata_r == `GCSU_SC_FULL_RESET)
                    full_reset_pulse <= 1'b1;
            end
            gauge_status_word <= {1'b0, full_lock_r, sealed_r, 1'b0, cal_r, board_cal_in, mdone_r, mfail_r,
                                  init_r, hib_r, slp_plus_r, sleep_mode_in, constant_power_in,
                                  resistance_update_off_in, vvalid_r, qupd_r}; // [R4] [R5]
        end
    end
endmodule

//--- tb/gauge_control_subcommand_unit_tb_top.sv
// self-checking bench for the gauge control subcommand unit
`timescale 1ns/1ps
`include "gcsu_defines.vh"
module gauge_control_subcommand_unit_tb_top;
    localparam int TICK = 100;
    localparam int PULSE = 20;
    // identity values are arbitrary
    localparam logic [15:0] IDV [4] = '{16'h1234, 16'h0100, 16'h0A5C, 16'h3C01};
    localparam logic [15:0] IDC [4] = '{`GCSU_SC_DEVTYPE, `GCSU_SC_FWREV, `GCSU_SC_CHEM, `GCSU_SC_FLASHREV};
    localparam logic [15:0] PRV [10] = '{16'h0000, 16'h0001, 16'h0002, 16'h0008, 16'h000D,
                                         16'h000E, 16'h0011, 16'h0012, 16'h0013, 16'h0014};
    localparam logic [15:0] HSC [4] = '{`GCSU_SC_HIB_SET, `GCSU_SC_SLP_SET, `GCSU_SC_HIB_CLR, `GCSU_SC_SLP_CLR};
    localparam logic [3:0]  HE = 4'b0011;
    localparam logic [3:0]  SE = 4'b0110;
    localparam logic [15:0] LCK [5] = '{`GCSU_SC_FACTORY, `GCSU_SC_ALGO_EN, `GCSU_SC_FULL_RESET,
                                        `GCSU_SC_SEAL, 16'h0033};
    logic        clk, reset, aie, therm, cblk, hexit, slp, bcal;
    logic        soc_int, bp, frp, fup;
    logic [15:0] st;
    wire         scl, sda, oe_n;
    int          n_mismatch = 0, tests_run = 0, seed, pw = 0, pw_last = 0, nfr = 0, nfu = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    gcsu_host_model host (.scl(scl), .sda(sda), .sda_oe_n(oe_n));
    gcsu_top #(.TICK_CYC(TICK), .PULSE_CYC(PULSE), .CAL_DELAY(3), .DEV_TYPE(IDV[0]), .FW_REV(IDV[1]),
               .CHEM_CODE(IDV[2]), .FLASH_REV(IDV[3])) dut (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_oe_n(oe_n),
        .auto_insert_detect_en(aie), .thermistor_present(therm), .charge_blocked_flag(cblk),
        .hibernate_exit(hexit), .sleep_mode_in(slp), .board_cal_in(bcal), .constant_power_in(1'b0),
        .resistance_update_off_in(1'b0), .soc_int(soc_int), .battery_present_flag(bp),
        .gauge_status_word(st), .factory_restore_pulse(frp), .full_reset_pulse(fup));
    // action pulses and interrupt width
    always @(posedge clk) begin
        nfr <= nfr + frp;
        nfu <= nfu + fup;
        pw <= soc_int ? pw + 1 : 0;
        if (!soc_int && pw != 0) pw_last <= pw;
    end
    function automatic logic [15:0] prev_exp(input logic [15:0] c);
        return (c > 16'h0009) ? 16'h0007 : c;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic sub(input logic [15:0] c);
        logic nak;
        slp = 1'($random(seed));
        bcal = 1'($random(seed));
        host.send_sub(`GCSU_I2C_ADDR, c, nak);
        chk(16'(nak), 16'h0000);
        cyc(10);
    endtask
    task automatic rd(input logic [15:0] c, output logic [15:0] w);
        sub(c);
        host.read_word(w);
        cyc(1);
    endtask
    task automatic wait_st(input int b, input int lim);
        int k;
        for (k = 0; k < lim && st[b] !== 1'b1; k++) cyc(1);
        chk(16'(st[b]), 16'h0001);
        if (k == lim) print_verdict;
    endtask
    initial begin
        logic [15:0] w, s0;
        int k;
        seed = 19161;
        reset = 1'b1;
        {aie, therm, cblk, hexit, slp, bcal} = 6'h00;
        repeat (3) @(posedge clk);
        #1 reset = 1'b0;
        cyc(3);
        chk(16'({soc_int, bp, st[6], st[3]}), 16'h0000);
        cyc(3 * TICK);
        chk(16'(st[7]), 16'h0000);
        for (k = 0; k < 4; k++) begin
            rd(IDC[k], w);
            chk(w, IDV[k]);
        end
        for (k = 0; k < 8; k++) begin
            s0 = PRV[$unsigned($random(seed)) % 10];
            sub(s0);
            rd(`GCSU_SC_LAST, w);
            chk(w, prev_exp(s0));
        end
        sub(`GCSU_SC_FWREV);
        sub(16'h0033);
        rd(`GCSU_SC_LAST, w);
        chk(w, `GCSU_SC_FWREV);
        sub(`GCSU_SC_SLP_CLR);
        for (k = 0; k < 4; k++) begin
            sub(HSC[k]);
            rd(`GCSU_SC_STATUS, w);
            chk(16'({w[6], w[5], w[4], w[10]}), 16'({HE[k], SE[k], slp, bcal}));
        end
        sub(`GCSU_SC_HIB_SET);
        hexit = 1'b1;
        cyc(1);
        hexit = 1'b0;
        rd(`GCSU_SC_STATUS, w);
        chk(16'(w[6]), 16'h0000);
        sub(`GCSU_SC_BAT_OUT);
        chk(16'(bp), 16'h0000);
        sub(`GCSU_SC_BAT_IN);
        chk(16'(bp), 16'h0001);
        aie = 1'b1;
        cyc(4);
        chk(16'(bp), 16'h0000);
        therm = 1'b1;
        cyc(4);
        chk(16'(bp), 16'h0001);
        aie = 1'b0;
        wait_st(7, 3 * TICK);
        sub(`GCSU_SC_MEASURE);
        wait_st(9, 3 * TICK);
        chk(16'(pw_last), 16'(PULSE));
        cblk = 1'b1;
        sub(`GCSU_SC_MEASURE);
        cblk = 1'b0;
        wait_st(8, 3 * TICK);
        wait_st(11, 6 * TICK);
        sub(`GCSU_SC_FACTORY);
        sub(`GCSU_SC_FULL_RESET);
        chk(16'(nfr + nfu), 16'h0002);
        sub(`GCSU_SC_SEAL);
        rd(`GCSU_SC_STATUS, s0);
        chk(s0 & 16'h6000, 16'h6000);
        for (k = 0; k < 5; k++) begin
            sub(LCK[k]);
            rd(`GCSU_SC_STATUS, w);
            chk(w & 16'hF3EF, s0 & 16'hF3EF);
        end
        chk(16'(nfr + nfu), 16'h0002);
        print_verdict;
    end
endmodule

//--- tb/gcsu_host_model.sv
// host-side serial bus master model
`timescale 1ns/1ps
`include "gcsu_defines.vh"
module gcsu_host_model (
    // serial pins
    output logic scl,
    output wire  sda,
    input  wire  sda_oe_n
);
    logic drv = 1'b1;
    logic ack;
    // pulled-up line, either party pulls low
    assign sda = drv & sda_oe_n;
    // host draws no load, so every measure window is quiet
    initial scl = 1'b1;
    task automatic bo(input logic b);
        #40 drv = b;
        #22 scl = 1'b1;
        #63 scl = 1'b0;
    endtask
    task automatic bi(output logic b);
        #40 drv = 1'b1;
        #22 scl = 1'b1;
        #40 b = sda;
        #23 scl = 1'b0;
    endtask
    task automatic sta;
        #40 drv = 1'b1;
        #22 scl = 1'b1;
        #40 drv = 1'b0;
        #40 scl = 1'b0;
    endtask
    task automatic sto;
        #40 drv = 1'b0;
        #22 scl = 1'b1;
        #40 drv = 1'b1;
        #40;
    endtask
    task automatic pb(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) bo(d[i]);
        bi(ack);
    endtask
    task automatic gb(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) bi(d[i]);
        bo(last);
    endtask
    task automatic send_sub(input logic [6:0] a, input logic [15:0] c, output logic nak);
        sta;
        pb({a, 1'b0});
        nak = ack;
        pb(8'h00);
        pb(c[7:0]);
        pb(c[15:8]);
        sto;
    endtask
    task automatic read_word(output logic [15:0] w);
        sta;
        pb({`GCSU_I2C_ADDR, 1'b0});
        pb(8'h00);
        sta;
        pb({`GCSU_I2C_ADDR, 1'b1});
        gb(w[7:0], 1'b0);
        gb(w[15:8], 1'b1);
        sto;
    endtask
endmodule

//--- tb/gcsu_props.sv
// port-level checker for the subcommand unit
`timescale 1ns/1ps
module gcsu_props #(
    parameter PULSE_CYC = 20
) (
    // clock and reset
    input wire        clk,
    input wire        reset,
    // watched pins
    input wire        auto_insert_detect_en,
    input wire        thermistor_present,
    input wire        hibernate_exit,
    input wire        sleep_mode_in,
    input wire        soc_int,
    input wire        battery_present_flag,
    input wire [15:0] gauge_status_word,
    input wire        factory_restore_pulse,
    input wire        full_reset_pulse
);
    wire [15:0] sw;
    int         pcnt_r;
    assign sw = gauge_status_word;
    // length of the current interrupt pulse
    always @(posedge clk) begin
        if (reset || !soc_int)
            pcnt_r <= 0;
        else
            pcnt_r <= pcnt_r + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_rst; $fell(reset) |-> !soc_int && !sw[6]; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    property p_pulse; $fell(soc_int) |-> pcnt_r == PULSE_CYC; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse width wrong");
    property p_init; $rose(sw[7]) |-> battery_present_flag || $past(battery_present_flag); endproperty
    a_init: assert property (p_init) else $error("init without battery");
    property p_follow;
        (auto_insert_detect_en && $stable(thermistor_present))[*3] |-> battery_present_flag == thermistor_present;
    endproperty
    a_follow: assert property (p_follow) else $error("battery flag not following");
    property p_sleep; $rose(sleep_mode_in) |-> ##[1:3] sw[4]; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep bit missing");
    property p_hibx; hibernate_exit |-> ##[1:3] !sw[6]; endproperty
    a_hibx: assert property (p_hibx) else $error("hibernate bit kept");
    property p_seal; $past(sw[13]) |-> sw[13] && sw[14]; endproperty
    a_seal: assert property (p_seal) else $error("sealed state lost");
    property p_lock; sw[13] |-> !factory_restore_pulse && !full_reset_pulse; endproperty
    a_lock: assert property (p_lock) else $error("restricted action while sealed");
    property p_cal; $rose(sw[11]) |-> sw[11][*8]; endproperty
    a_cal: assert property (p_cal) else $error("calibration bit too short");
    c_meas: cover property ($fell(soc_int));
    c_seal: cover property ($rose(sw[13]));
    c_cal: cover property ($rose(sw[11]));
endmodule
bind gcsu_top gcsu_props #(.PULSE_CYC(PULSE_CYC)) u_props (
    .clk(clk), .reset(reset), .auto_insert_detect_en(auto_insert_detect_en),
    .thermistor_present(thermistor_present), .hibernate_exit(hibernate_exit),
    .sleep_mode_in(sleep_mode_in), .soc_int(soc_int), .battery_present_flag(battery_present_flag),
    .gauge_status_word(gauge_status_word), .factory_restore_pulse(factory_restore_pulse),
    .full_reset_pulse(full_reset_pulse));
